/* shared/cim_pkg.sv */
package cim_pkg;
  // function codes held in a binding register
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_RUN_RST = 4'h1;
  localparam logic [3:0] FN_RESET = 4'h2;
  localparam logic [3:0] FN_HOLD = 4'h3;
  localparam logic [3:0] FN_ADVANCE = 4'h4;
  localparam logic [3:0] FN_FIXED = 4'h5;
  localparam logic [3:0] FN_MANUAL = 4'h6;
  localparam logic [3:0] FN_LOGIC = 4'h7;
  localparam logic [3:0] FN_PAT2 = 4'h8;
  localparam logic [3:0] FN_PAT3 = 4'h9;
  localparam logic [3:0] FN_PAT4 = 4'hA;
  localparam logic [3:0] FN_PAT5 = 4'hB;
  localparam int NUM_FUNCS = 12;
  // channel binding field
  localparam logic [1:0] CH_ONE = 2'h1;
  localparam logic [1:0] CH_TWO = 2'h2;
  localparam logic [1:0] CH_BOTH = 2'h3;
  localparam int NUM_INPUTS = 10;
  localparam int OPT_FIRST = 4;
  localparam int PAT_LOW = 4;
  localparam int PAT_HIGH = 7;
  // register byte offsets
  localparam logic [7:0] OFF_BIND0 = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_ACTION = 8'h30;
  localparam logic [7:0] OFF_LOCK = 8'h34;
  // field positions
  localparam int BIND_FUNC_LSB = 0;
  localparam int BIND_CHAN_LSB = 4;
  localparam int CTRL_OPTION = 0;
  localparam int CTRL_DUAL = 1;
  localparam int CTRL_INDICATOR = 2;
  localparam int ACT_CH2_LSB = 16;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // pattern numbers
  localparam logic [4:0] PAT_OPEN_NO = 5'h01;
  localparam logic [4:0] PAT_MAX2 = 5'h03;
  localparam logic [4:0] PAT_MAX3 = 5'h07;
  localparam logic [4:0] PAT_MAX4 = 5'h0F;
  localparam logic [4:0] PAT_MAX5 = 5'h14;
  // contact stability time
  localparam int STABLE_TIME_MS = 1000;
  localparam int CLK_FREQ_MHZ = 250;
  localparam int STABLE_CYCLES = STABLE_TIME_MS * 1000 * CLK_FREQ_MHZ;

  typedef struct packed {
    logic [1:0] chan;
    logic [3:0] func;
  } bind_t;

  typedef struct packed {
    logic run;
    logic force_reset;
    logic hold;
    logic advance;
    logic fixed_value;
    logic manual;
    logic pattern_valid;
    logic [4:0] pattern_no;
  } chan_act_t;

  localparam bind_t BIND_RUN = '{chan: CH_ONE, func: FN_RUN_RST};
  localparam bind_t BIND_FREE = '{chan: CH_ONE, func: FN_NONE};

  function automatic logic [2:0] pat_bits(input logic [3:0] f);
    unique case (f)
      FN_PAT2: pat_bits = 3'h2;
      FN_PAT3: pat_bits = 3'h3;
      FN_PAT4: pat_bits = 3'h4;
      FN_PAT5: pat_bits = 3'h5;
      default: pat_bits = 3'h0;
    endcase
  endfunction : pat_bits

  function automatic logic [4:0] pat_max(input logic [3:0] f);
    unique case (f)
      FN_PAT2: pat_max = PAT_MAX2;
      FN_PAT3: pat_max = PAT_MAX3;
      FN_PAT4: pat_max = PAT_MAX4;
      default: pat_max = PAT_MAX5;
    endcase
  endfunction : pat_max
endpackage : cim_pkg

/* logic/contact_filter.sv */
`timescale 1ns/10ps
module contact_filter
  import cim_pkg::*;
#(
  parameter int STABLE = STABLE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  localparam logic [27:0] LAST = 28'(STABLE - 1);
  logic [2:0] sync_q;
  logic [27:0] cnt_q;
  logic level_q;
  wire agree = sync_q[1] == sync_q[2];
  wire differs = sync_q[2] != level_q;

  assign level = level_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync_q <= 3'h0;
      cnt_q <= 28'h0000000;
      level_q <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], pin};
      if (!agree || !differs)
        cnt_q <= 28'h0000000;
      else if (cnt_q == LAST)
      begin
        level_q <= sync_q[2];
        cnt_q <= 28'h0000000;
      end
      else
        cnt_q <= cnt_q + 28'h0000001;
    end
  end

  stable_change_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    $changed(level_q) |-> $past(cnt_q) == LAST)
    else $error("filtered level changed before stable time");
endmodule : contact_filter

/* logic/pattern_number.sv */
`timescale 1ns/10ps
module pattern_number
  import cim_pkg::*;
(
  input wire logic [4:0] bits,
  input wire logic [3:0] func,
  output logic [4:0] number
);
  wire [2:0] width = pat_bits(func);
  wire [4:0] mask = 5'((6'h01 << width) - 6'h01);
  wire [4:0] raw = bits & mask;
  wire [4:0] top = pat_max(func);

  // open inputs select the first pattern
  assign number = (raw == 5'h00) ? PAT_OPEN_NO :
                  (raw > top) ? top : raw;
endmodule : pattern_number

/* logic/contact_input_function_mapper.sv */
// Notes on behaviour
// - input one always drives run/reset toggle
// - inputs two to ten selectable; five-ten optional
// - dual loop binds channel one, two, both
// - two/three-bit pattern only on five, eight
// - four/five-bit pattern only on five
// - run/reset edge toggled, never inhibited
// - forced reset follows input level
// - hold pauses control while input active
// - advance on activation, ignored during hold
// - fixed-value mode while input active
// - manual while active, ignored during autotuning
// - logic operand passes input, no channel
// - pattern select level, ignored in fixed mode
// - inhibiting condition suppresses the function
// - level functions follow filtered input exactly
// - edge functions act on each activation: run toggles, advance pulses unless hold is active
// - state must stay one second to count
// - bound functions locked from front panel
// - duplicates: lowest numbered input wins
// - pattern binding clears consumed higher inputs
// - unbinding keeps action, except logic operand and pattern valid
// - binary pattern number, open means one
`timescale 1ns/10ps
module contact_input_function_mapper
  import cim_pkg::*;
#(
  parameter int STABLE = STABLE_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_INPUTS-1:0] contact_input,
  input wire logic autotuning,
  input wire logic fixed_mode_panel,
  output chan_act_t channel_one,
  output chan_act_t channel_two,
  output logic [NUM_INPUTS-1:0] logic_operand,
  output logic [NUM_FUNCS-1:0] panel_lock_one,
  output logic [NUM_FUNCS-1:0] panel_lock_two
);
  function automatic logic [9:0] first_hot(input logic [9:0] v);
    first_hot = v & (~v + 10'h001);
  endfunction : first_hot

  function automatic logic covers(input logic [1:0] c, input int ch);
    covers = (ch == 0) ? c[0] : c[1];
  endfunction : covers

  bind_t bind_q [NUM_INPUTS];
  bind_t bind_d [NUM_INPUTS];
  logic [2:0] ctrl_q;
  logic [NUM_INPUTS-1:0] filt;
  logic [NUM_INPUTS-1:0] filt_q;
  logic [7:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic rd_done_q;
  logic [31:0] rdata_q;
  chan_act_t act_q [2];
  logic [NUM_FUNCS-1:0] lock_q [2];
  logic [NUM_INPUTS-1:0] operand_q;

  // contact conditioning
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_filt
      contact_filter #(.STABLE(STABLE)) u_filt (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(contact_input[gi]),
        .level(filt[gi])
      );
    end
  endgenerate

  wire option_fitted = ctrl_q[CTRL_OPTION];
  wire dual_loop = ctrl_q[CTRL_DUAL];
  wire external_select_indicator = ctrl_q[CTRL_INDICATOR];
  // optional inputs vanish when not fitted
  wire [NUM_INPUTS-1:0] present = option_fitted ? 10'h3FF : 10'h00F;

  // bus address phase and write decode
  wire take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire in_bind = addr_q < OFF_CTRL;
  wire [3:0] wr_idx = addr_q[5:2];
  wire [3:0] wr_func = hwdata[BIND_FUNC_LSB +: 4];
  wire [1:0] wr_chan_raw = hwdata[BIND_CHAN_LSB +: 2];
  // single loop and empty field fall back to channel one
  wire [1:0] wr_chan = (!dual_loop || wr_chan_raw == 2'h0) ? CH_ONE
                       : wr_chan_raw;
  wire wr_pat = pat_bits(wr_func) != 3'h0;
  // pattern selects only at their base inputs
  wire pat_ok = !wr_pat ||
                (wr_idx == 4'(PAT_LOW)) ||
                (wr_idx == 4'(PAT_HIGH) &&
                 (wr_func == FN_PAT2 || wr_func == FN_PAT3));
  wire bind_wr = wr_q && in_bind && (wr_idx != 4'h0) &&
                 (wr_idx < 4'(NUM_INPUTS)) && (wr_func <= FN_PAT5) &&
                 pat_ok && (option_fitted || wr_idx < 4'(OPT_FIRST));
  wire ctrl_wr = wr_q && (addr_q == OFF_CTRL);

  always_comb
  begin
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      bind_d[i] = bind_q[i];
      if (bind_wr && wr_idx == 4'(i))
      begin
        bind_d[i].func = wr_func;
        bind_d[i].chan = wr_chan;
      end
      // inputs consumed as pattern bits lose their function
      if (bind_wr && wr_pat && (4'(i) > wr_idx) &&
          (4'(i) < wr_idx + 4'(pat_bits(wr_func))))
        bind_d[i].func = FN_NONE;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_INPUTS; i++)
        bind_q[i] <= (i == 0) ? BIND_RUN : BIND_FREE;
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      bind_q <= bind_d;
      if (ctrl_wr)
        ctrl_q <= hwdata[2:0];
    end
  end

  // reads take one wait state so a just-written value is seen
  wire [3:0] rd_idx = addr_q[5:2];
  bind_t rd_bind;
  assign rd_bind = bind_q[rd_idx < 4'(NUM_INPUTS) ? rd_idx : 4'h0];
  wire [31:0] act_word = {4'h0, act_q[1], 4'h0, act_q[0]};
  wire [31:0] rd_mux =
    (in_bind && rd_idx < 4'(NUM_INPUTS)) ? {26'h0, rd_bind} :
    (addr_q == OFF_CTRL) ? {29'h0, ctrl_q} :
    (addr_q == OFF_STATUS) ? {22'h0, filt_q} :
    (addr_q == OFF_ACTION) ? act_word :
    (addr_q == OFF_LOCK) ? {4'h0, lock_q[1], 4'h0, lock_q[0]} :
    32'h00000000;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_done_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      if (hreadyout)
      begin
        // high address bits set: park on an unmapped offset, no aliasing
        addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
        wr_q <= take && hwrite;
        rd_q <= take && !hwrite;
        rd_done_q <= 1'b0;
      end
      else
      begin
        rdata_q <= rd_mux;
        rd_done_q <= 1'b1;
      end
    end
  end

  assign hreadyout = !(rd_q && !rd_done_q);
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_q;

  // binding matches per channel and function
  logic [9:0] match [2][NUM_FUNCS];
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      for (int f = 0; f < NUM_FUNCS; f++)
        for (int i = 0; i < NUM_INPUTS; i++)
          match[c][f][i] = present[i] && bind_q[i].func == 4'(f) &&
                           (f == 7 || covers(bind_q[i].chan, c));
  end

  // logic operand stops at once when unbound
  wire [9:0] operand_d;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_oper
      assign operand_d[gi] = match[0][7][gi] & filt[gi];
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++)
    begin : g_chan
      // only the lowest numbered input counts
      wire [9:0] own_run = first_hot(match[gc][1]);
      wire [9:0] own_rst = first_hot(match[gc][2]);
      wire [9:0] own_hold = first_hot(match[gc][3]);
      wire [9:0] own_step = first_hot(match[gc][4]);
      wire [9:0] own_fix = first_hot(match[gc][5]);
      wire [9:0] own_man = first_hot(match[gc][6]);
      wire [9:0] pat_any = match[gc][8] | match[gc][9] |
                           match[gc][10] | match[gc][11];
      wire [9:0] own_pat = first_hot(pat_any);
      wire run_rise = |(own_run & filt & ~filt_q);
      wire step_rise = |(own_step & filt & ~filt_q);
      wire [3:0] pat_func = own_pat[PAT_LOW] ? bind_q[PAT_LOW].func
                            : bind_q[PAT_HIGH].func;
      wire [4:0] pat_raw = own_pat[PAT_LOW] ? filt[8:4]
                           : {2'h0, filt[9:7]};
      wire [4:0] pat_no;
      wire fix_now = act_q[gc].fixed_value || fixed_mode_panel;
      chan_act_t nxt;

      pattern_number u_pat (
        .bits(pat_raw),
        .func(pat_func),
        .number(pat_no)
      );

      always_comb
      begin
        nxt = act_q[gc];
        if (run_rise)
          nxt.run = !act_q[gc].run;
        if (|own_rst)
          nxt.force_reset = |(own_rst & filt);
        if (|own_hold)
          nxt.hold = |(own_hold & filt);
        if (|own_fix)
          nxt.fixed_value = |(own_fix & filt);
        if (|own_man)
          nxt.manual = |(own_man & filt);
        nxt.advance = step_rise && !act_q[gc].hold;
        // pattern only with indicator lit, not fixed
        nxt.pattern_valid = (|own_pat) && external_select_indicator &&
                            !fix_now;
        nxt.pattern_no = (|own_pat) ? pat_no : act_q[gc].pattern_no;
      end

      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          act_q[gc] <= '0;
          lock_q[gc] <= '0;
        end
        else
        begin
          act_q[gc] <= nxt;
          // panel locked out of every bound function
          for (int f = 1; f < NUM_FUNCS; f++)
            lock_q[gc][f] <= |match[gc][f];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      filt_q <= '0;
      operand_q <= '0;
    end
    else
    begin
      filt_q <= filt;
      operand_q <= operand_d;
    end
  end

  always_comb
  begin
    channel_one = act_q[0];
    channel_two = act_q[1];
    channel_one.manual = act_q[0].manual && !autotuning;
    channel_two.manual = act_q[1].manual && !autotuning;
  end
  assign logic_operand = operand_q;
  assign panel_lock_one = lock_q[0];
  assign panel_lock_two = lock_q[1];

  run_fixed_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    bind_q[0] == BIND_RUN)
    else $error("input one lost its run binding");

  pat_place_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    bind_wr && wr_pat |-> wr_idx == 4'(PAT_LOW) || wr_idx == 4'(PAT_HIGH))
    else $error("pattern select accepted at wrong input");

  pat_five_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    bind_q[PAT_HIGH].func != FN_PAT4 && bind_q[PAT_HIGH].func != FN_PAT5)
    else $error("wide pattern select at input eight");

  run_toggle_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    g_chan[0].run_rise |=> act_q[0].run != $past(act_q[0].run))
    else $error("run did not toggle on activation");

  step_hold_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    act_q[0].hold && !$past(rst) |=> !act_q[0].advance)
    else $error("advance issued during hold");

  man_at_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    autotuning |-> !channel_one.manual && !channel_two.manual)
    else $error("manual output while autotuning");

  pat_fix_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    act_q[0].fixed_value ##1 act_q[0].fixed_value
    |-> !act_q[0].pattern_valid)
    else $error("pattern select honoured in fixed mode");

  operand_stop_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    !match[0][7][3] |=> !logic_operand[3])
    else $error("logic operand kept after unbinding");

  consumed_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    bind_wr && wr_idx == 4'(PAT_LOW) && wr_func == FN_PAT5
    |=> bind_q[8].func == FN_NONE && bind_q[5].func == FN_NONE)
    else $error("consumed pattern inputs kept their function");

  number_range_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    g_chan[0].pat_no != 5'h00 && g_chan[0].pat_no <= PAT_MAX5)
    else $error("pattern number out of range");
endmodule : contact_input_function_mapper

/* sim/contact_bank.sv */
`timescale 1ns/10ps
module contact_bank
#(
  parameter int HOLD = 10
)
(
  input wire logic sys_clk,
  input wire logic [9:0] want,
  input wire logic [9:0] glitch,
  output logic [9:0] pins
);
  logic [9:0] held_q = 10'h000;
  int age_q = 0;
  // each new state kept long enough
  always @(posedge sys_clk)
  begin
    if (want !== held_q && age_q >= HOLD)
    begin
      held_q <= want;
      age_q <= 0;
    end
    else if (age_q < HOLD)
    begin
      age_q <= age_q + 1;
    end
  end
  // glitch only when a scenario commands a too-short bounce
  assign pins = held_q ^ glitch;
endmodule : contact_bank

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import cim_pkg::*;
  localparam int STB = 8;
  typedef struct {
    logic [3:0] f;
    logic [1:0] c;
    logic at;
    logic [11:0] e1;
    logic [11:0] e2;
  } row_t;
  row_t rows [5] = '{
    '{FN_RESET, CH_ONE, 1'b0, 12'h400, 12'h000},
    '{FN_HOLD, CH_TWO, 1'b0, 12'h000, 12'h200},
    '{FN_FIXED, CH_BOTH, 1'b0, 12'h080, 12'h080},
    '{FN_MANUAL, CH_ONE, 1'b0, 12'h040, 12'h000},
    '{FN_MANUAL, CH_ONE, 1'b1, 12'h000, 12'h000}};
  logic [4:0] pv [4] = '{5'h00, 5'h05, 5'h14, 5'h1F};
  logic [4:0] pe [4] = '{5'h01, 5'h05, 5'h14, 5'h14};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] want = 10'h000;
  logic [9:0] glitch = 10'h000;
  logic autotuning = 1'b0;
  logic fixed_mode_panel = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [9:0] pins;
  chan_act_t ch1;
  chan_act_t ch2;
  logic [9:0] logic_operand;
  logic [11:0] lock1;
  logic [11:0] lock2;
  logic [31:0] rd;
  logic [31:0] rd0;
  int err_count = 0;
  int checks = 0;
  int step_cnt = 0;
  int n0;

  always #2 sys_clk = ~sys_clk;
  // one-cycle pulse sampled mid-cycle, away from the edge race
  always @(negedge sys_clk)
    if (ch1.advance === 1'b1)
      step_cnt++;

  contact_bank #(.HOLD(STB + 2)) i_contact_bank (.sys_clk(sys_clk),
    .want(want), .glitch(glitch), .pins(pins));
  contact_input_function_mapper #(.STABLE(STB))
    i_contact_input_function_mapper (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .contact_input(pins), .autotuning(autotuning),
    .fixed_mode_panel(fixed_mode_panel), .channel_one(ch1),
    .channel_two(ch2), .logic_operand(logic_operand),
    .panel_lock_one(lock1), .panel_lock_two(lock2));

  task automatic final_report;
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // ready is looked at just before the edge it settles for
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t bus hang", $time);
      final_report();
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdat = hrdata;
    @(posedge sys_clk);
    hsel <= 1'b0;
  endtask : bus

  task automatic wrd(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, rd);
    bus(1'b0, a, 32'h0, rd);
  endtask : wrd

  task automatic settle(input logic [9:0] v);
    @(posedge sys_clk);
    want <= v;
    repeat (STB + 14) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({6'h0, hreadyout, hresp, ch1, ch2}, 32'h02000000);
    chk({8'h0, lock1, lock2}, 32'h0);
    chk({22'h0, logic_operand}, 32'h0);
    wrd(OFF_BIND0, 32'h13);
    chk(rd, 32'h11);
    wrd(8'h10, 32'h13);
    chk(rd, 32'h10);
    wrd(8'hFC, 32'h55);
    chk(rd, 32'h0);
    wrd(OFF_CTRL, 32'h3);
    foreach (rows[i])
    begin
      wrd(8'h08, {26'h0, rows[i].c, rows[i].f});
      chk(rd, {26'h0, rows[i].c, rows[i].f});
      autotuning <= rows[i].at;
      settle(10'h004);
      chk(ch1, rows[i].e1);
      chk(ch2, rows[i].e2);
      chk({lock2[rows[i].f], lock1[rows[i].f]}, rows[i].c);
      settle(10'h000);
      chk({ch1, ch2}, 32'h0);
    end
    @(posedge sys_clk);
    autotuning <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      settle({9'h0, ~k[0]});
      chk(ch1.run, (k < 2) ? 32'h1 : 32'h0);
    end
    wrd(8'h04, {26'h1, FN_ADVANCE});
    wrd(8'h08, {26'h1, FN_HOLD});
    n0 = step_cnt;
    settle(10'h002);
    chk(step_cnt - n0, 32'h1);
    settle(10'h004);
    n0 = step_cnt;
    settle(10'h006);
    chk(step_cnt - n0, 32'h0);
    wrd(8'h08, 32'h10);
    settle(10'h000);
    chk(ch1.hold, 32'h1);
    wrd(8'h08, {26'h1, FN_HOLD});
    wrd(8'h04, {26'h1, FN_HOLD});
    settle(10'h004);
    chk(ch1.hold, 32'h0);
    settle(10'h000);
    @(posedge sys_clk);
    glitch <= 10'h002;
    repeat (STB - 2) @(posedge sys_clk);
    glitch <= 10'h000;
    settle(10'h000);
    chk(ch1.hold, 32'h0);
    wrd(8'h0C, {26'h1, FN_LOGIC});
    settle(10'h008);
    chk(logic_operand, 32'h8);
    wrd(8'h0C, 32'h0);
    settle(10'h008);
    chk(logic_operand, 32'h0);
    settle(10'h000);
    wrd(OFF_CTRL, 32'h7);
    wrd(8'h14, {26'h1, FN_MANUAL});
    wrd(8'h10, {26'h1, FN_PAT5});
    bus(1'b0, 8'h14, 32'h0, rd);
    chk(rd & 32'hF, 32'h0);
    bus(1'b0, 8'h1C, 32'h0, rd0);
    wrd(8'h1C, {26'h1, FN_PAT4});
    chk(rd, rd0);
    bus(1'b0, 8'h0C, 32'h0, rd0);
    wrd(8'h0C, {26'h1, FN_PAT2});
    chk(rd, rd0);
    foreach (pv[i])
    begin
      settle({1'b0, pv[i], 4'h0});
      chk({ch1.pattern_valid, ch1.pattern_no}, {26'h0, 1'b1, pe[i]});
    end
    @(posedge sys_clk);
    fixed_mode_panel <= 1'b1;
    settle({1'b0, pv[1], 4'h0});
    chk(ch1.pattern_valid, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h00000050);
    bus(1'b0, OFF_ACTION, 32'h0, rd);
    chk(rd, 32'h00000005);
    bus(1'b0, OFF_LOCK, 32'h0, rd);
    chk(rd, 32'h0000080A);
    // second reset in mid-run must restore the default bindings
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({6'h0, hreadyout, hresp, ch1, ch2}, 32'h02000000);
    bus(1'b0, OFF_BIND0, 32'h0, rd);
    chk(rd, 32'h11);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk(rd, 32'h10);
    bus(1'b0, OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    final_report();
  end
endmodule : tb_top
